// *** include/sdcd_pkg.sv ***
package sdcd_pkg;
	// decoded command set, one per cycle
	typedef enum logic [3:0] {
		SDCD_CMD_DESELECT   = 4'h0,
		SDCD_CMD_NOP        = 4'h1,
		SDCD_CMD_ACTIVATE   = 4'h2,
		SDCD_CMD_READ       = 4'h3,
		SDCD_CMD_WRITE      = 4'h4,
		SDCD_CMD_PRECHARGE  = 4'h5,
		SDCD_CMD_MODE_SET   = 4'h6,
		SDCD_CMD_REFRESH    = 4'h7,
		SDCD_CMD_SELF_ENTRY = 4'h8,
		SDCD_CMD_BURST_STOP = 4'h9
	} sdcd_cmd_t;

	// power states, gray along idle -> pdown -> suspend -> self
	typedef enum logic [1:0] {
		SDCD_PS_RUN     = 2'h0,
		SDCD_PS_PDOWN   = 2'h1,
		SDCD_PS_SUSPEND = 2'h3,
		SDCD_PS_SELF    = 2'h2
	} sdcd_pwr_t;

	localparam int unsigned SDCD_BANKS     = 4;
	localparam int unsigned SDCD_ADDR_W    = 13;
	localparam int unsigned SDCD_COL_W     = 10;
	localparam int unsigned SDCD_AP_BIT    = 10;
	localparam int unsigned SDCD_BURST_W   = 9;
	localparam int unsigned SDCD_MODE_BL_LO = 0;
	localparam int unsigned SDCD_MODE_BL_HI = 2;
	localparam logic [2:0]  SDCD_BL_1      = 3'h0;
	localparam logic [2:0]  SDCD_BL_2      = 3'h1;
	localparam logic [2:0]  SDCD_BL_4      = 3'h2;
	localparam logic [2:0]  SDCD_BL_8      = 3'h3;
	localparam logic [2:0]  SDCD_BL_PAGE   = 3'h7;
	localparam logic [8:0]  SDCD_LEN_1     = 9'h001;
	localparam logic [8:0]  SDCD_LEN_2     = 9'h002;
	localparam logic [8:0]  SDCD_LEN_4     = 9'h004;
	localparam logic [8:0]  SDCD_LEN_8     = 9'h008;
	localparam logic [8:0]  SDCD_LEN_PAGE  = 9'h1FF;
	localparam logic [8:0]  SDCD_ONE       = 9'h001;
	localparam logic [12:0] SDCD_MODE_RST  = 13'h0000;
endpackage

// *** include/sdcd_bank_if.sv ***
`timescale 1ns/1ps
// bank open/close requests from decoder to bank tracker
interface sdcd_bank_if;
	logic       open_v;
	logic       close_v;
	logic       close_all;
	logic [1:0] bank;
	// burst-end close has its own lane so a command in that cycle cannot mask it
	logic       ap_close_v;
	logic [1:0] ap_bank;
	logic [3:0] active;
	modport dec (output open_v, output close_v, output close_all, output bank,
		output ap_close_v, output ap_bank, input active);
	modport trk (input open_v, input close_v, input close_all, input bank,
		input ap_close_v, input ap_bank, output active);
endinterface

// *** rtl/sdcd_bank_track.sv ***
`timescale 1ns/1ps
module sdcd_bank_track (
	input  wire logic   clk,
	input  wire logic   rst_n,
	sdcd_bank_if.trk    bif
);
	typedef struct packed {
		logic [3:0] active;
	} sdcd_trk_st_t;

	sdcd_trk_st_t st_q;
	sdcd_trk_st_t st_d;

	// per-bank open/close; a close of a bank wins over an open of that same bank
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < sdcd_pkg::SDCD_BANKS; i++) begin
			if ((bif.close_v && (bif.close_all || bif.bank == 2'(i))) ||
			    (bif.ap_close_v && bif.ap_bank == 2'(i))) begin
				st_d.active[i] = 1'b0;
			end else if (bif.open_v && bif.bank == 2'(i)) begin
				st_d.active[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bif.active = st_q.active;
endmodule

// *** rtl/sdcd_decode.sv ***
`timescale 1ns/1ps
// Functional notes
// RQ1: sample all control strobes each rising edge; decode one command per cycle.
// RQ2: strobe encodings with chip select low map to the eight commands; high deselects.
// RQ3: previous and current clock enable split auto refresh from self refresh entry.
// RQ4: controller activates only idle banks; reads/writes only active banks.
// RQ5: no power-down entry while a burst runs.
// RQ6: clock enable low during a burst freezes the burst (clock suspend).
// RQ7: controller always programs the mode register before use.
// RQ8: controller holds no-operation and runs clock while supplies ramp.
// RQ9: controller waits 200 us, then precharges all banks first.
// RQ10: controller holds data mask and clock enable high during the wait.
// RQ11: mode register set only after all banks precharged.
// RQ12: at least eight auto refreshes during initialization.
// RQ13: latch row on activate, column on read or write.
// RQ14: A10 on read/write requests auto precharge at burst end.
// RQ15: A10 on precharge closes all banks, else the selected bank.
// RQ16: clock enable rising with deselect/nop exits power-down or self refresh.
// RQ17: data mask high blocks write store and read drive.
module sdcd_decode (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                chip_select_n,
	input  wire logic                row_strobe_n,
	input  wire logic                column_strobe_n,
	input  wire logic                write_enable_n,
	input  wire logic                clock_enable,
	input  wire logic                data_mask,
	input  wire logic                bank_select_lo,
	input  wire logic                bank_select_hi,
	input  wire logic [12:0]         addr,
	output sdcd_pkg::sdcd_cmd_t      cmd,
	output sdcd_pkg::sdcd_pwr_t      pwr_state,
	output logic [3:0]               bank_active,
	output logic [12:0]              row_addr,
	output logic [9:0]               col_addr,
	output logic [1:0]               cmd_bank,
	output logic                     auto_precharge_flag,
	output logic [12:0]              mode_word,
	output logic                     burst_busy,
	output logic                     burst_is_write,
	output logic                     data_write_en,
	output logic                     data_drive_en
);
	typedef struct packed {
		logic                cke_prev;
		sdcd_pkg::sdcd_cmd_t cmd;
		sdcd_pkg::sdcd_pwr_t pwr;
		logic [12:0]         row;
		logic [9:0]          col;
		logic [1:0]          bank;
		logic                ap;
		logic [12:0]         mode;
		logic [8:0]          left;
		logic                wr;
		logic                wen;
		logic                den;
	} sdcd_st_t;

	sdcd_st_t   st_q;
	sdcd_st_t   st_d;
	sdcd_bank_if bif();
	sdcd_pkg::sdcd_cmd_t dec;
	logic [1:0] bsel;
	logic       ap_in;
	logic [8:0] blen;
	logic       bursting;
	logic       run;

	assign bsel     = {bank_select_hi, bank_select_lo};
	assign ap_in    = addr[sdcd_pkg::SDCD_AP_BIT];
	assign bursting = (st_q.left != '0);

	// burst length from the programmed mode; reserved codes act as one beat
	always_comb begin
		unique case (st_q.mode[sdcd_pkg::SDCD_MODE_BL_HI:sdcd_pkg::SDCD_MODE_BL_LO])
			sdcd_pkg::SDCD_BL_2: blen = sdcd_pkg::SDCD_LEN_2;
			sdcd_pkg::SDCD_BL_4: blen = sdcd_pkg::SDCD_LEN_4;
			sdcd_pkg::SDCD_BL_8: blen = sdcd_pkg::SDCD_LEN_8;
			sdcd_pkg::SDCD_BL_PAGE: blen = sdcd_pkg::SDCD_LEN_PAGE;
			default:             blen = sdcd_pkg::SDCD_LEN_1;
		endcase
	end

	// RQ1 RQ2 RQ3 command truth table
	always_comb begin
		dec = sdcd_pkg::SDCD_CMD_NOP;
		if (chip_select_n) begin
			dec = sdcd_pkg::SDCD_CMD_DESELECT;
		end else begin
			unique case ({row_strobe_n, column_strobe_n, write_enable_n})
				3'h3: dec = sdcd_pkg::SDCD_CMD_ACTIVATE;
				3'h4: dec = sdcd_pkg::SDCD_CMD_WRITE;
				3'h5: dec = sdcd_pkg::SDCD_CMD_READ;
				3'h2: dec = sdcd_pkg::SDCD_CMD_PRECHARGE;
				3'h0: dec = sdcd_pkg::SDCD_CMD_MODE_SET;
				3'h1: dec = clock_enable ? sdcd_pkg::SDCD_CMD_REFRESH
				                         : sdcd_pkg::SDCD_CMD_SELF_ENTRY;
				3'h6: dec = sdcd_pkg::SDCD_CMD_BURST_STOP;
				3'h7: dec = sdcd_pkg::SDCD_CMD_NOP;
			endcase
		end
	end

	// commands only take effect in run state with clock enable high the cycle before
	assign run = (st_q.pwr == sdcd_pkg::SDCD_PS_RUN) && st_q.cke_prev;

	always_comb begin
		st_d          = st_q;
		st_d.cke_prev = clock_enable;
		st_d.cmd      = run ? dec : sdcd_pkg::SDCD_CMD_NOP;
		bif.open_v    = 1'b0;
		bif.close_v   = 1'b0;
		bif.close_all = 1'b0;
		bif.bank      = bsel;
		bif.ap_close_v = 1'b0;
		bif.ap_bank    = st_q.bank;
		unique case (st_q.pwr)
			sdcd_pkg::SDCD_PS_RUN: begin
				if (st_q.cke_prev && !clock_enable) begin
					// RQ6 suspend in burst
					if (bursting) begin
						st_d.pwr = sdcd_pkg::SDCD_PS_SUSPEND;
					// RQ3 self refresh entry
					end else if (dec == sdcd_pkg::SDCD_CMD_SELF_ENTRY) begin
						st_d.pwr = sdcd_pkg::SDCD_PS_SELF;
					// RQ5 power-down only when idle
					end else begin
						st_d.pwr = sdcd_pkg::SDCD_PS_PDOWN;
					end
				end
				// burst advances only while the clock is not suspended
				if (bursting) begin
					st_d.left = st_q.left - sdcd_pkg::SDCD_ONE;
					// RQ14 close bank at burst end
					if (st_q.left == sdcd_pkg::SDCD_ONE && st_q.ap) begin
						bif.ap_close_v = 1'b1;
					end
				end
				if (run) begin
					unique case (dec)
						sdcd_pkg::SDCD_CMD_ACTIVATE: begin
							// RQ13 row latch
							st_d.row    = addr;
							st_d.bank   = bsel;
							bif.open_v  = 1'b1;
						end
						sdcd_pkg::SDCD_CMD_READ, sdcd_pkg::SDCD_CMD_WRITE: begin
							// RQ13 column latch
							st_d.col  = addr[sdcd_pkg::SDCD_COL_W-1:0];
							st_d.bank = bsel;
							// RQ14 auto precharge request
							st_d.ap   = ap_in;
							st_d.left = blen;
							st_d.wr   = (dec == sdcd_pkg::SDCD_CMD_WRITE);
						end
						sdcd_pkg::SDCD_CMD_PRECHARGE: begin
							// RQ15 single or all banks
							bif.close_v   = 1'b1;
							bif.close_all = ap_in;
							bif.bank      = bsel;
						end
						sdcd_pkg::SDCD_CMD_MODE_SET: begin
							st_d.mode = addr;
						end
						sdcd_pkg::SDCD_CMD_BURST_STOP: begin
							st_d.left = '0;
						end
						default: begin
						end
					endcase
				end
			end
			// RQ16 exit on cke rise with deselect or nop
			sdcd_pkg::SDCD_PS_PDOWN, sdcd_pkg::SDCD_PS_SELF: begin
				if (clock_enable && (dec == sdcd_pkg::SDCD_CMD_DESELECT ||
				    dec == sdcd_pkg::SDCD_CMD_NOP)) begin
					st_d.pwr = sdcd_pkg::SDCD_PS_RUN;
				end
			end
			// RQ6 suspend resumes on cke alone
			sdcd_pkg::SDCD_PS_SUSPEND: begin
				if (clock_enable) begin
					st_d.pwr = sdcd_pkg::SDCD_PS_RUN;
				end
			end
		endcase
		// RQ17 data mask gates data path while a bank is active
		st_d.wen = (|bif.active) && !data_mask && st_q.wr && bursting;
		st_d.den = (|bif.active) && !data_mask && !st_q.wr && bursting;
	end

	// mode register is not trusted after power-up; reset to a neutral word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q          <= '0;
			st_q.cmd      <= sdcd_pkg::SDCD_CMD_NOP;
			st_q.pwr      <= sdcd_pkg::SDCD_PS_RUN;
			st_q.mode     <= sdcd_pkg::SDCD_MODE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	sdcd_bank_track u_track (
		.clk   (clk),
		.rst_n (rst_n),
		.bif   (bif)
	);

	assign cmd                 = st_q.cmd;
	assign pwr_state           = st_q.pwr;
	assign bank_active         = bif.active;
	assign row_addr            = st_q.row;
	assign col_addr            = st_q.col;
	assign cmd_bank            = st_q.bank;
	assign auto_precharge_flag = st_q.ap;
	assign mode_word           = st_q.mode;
	assign burst_busy          = bursting;
	assign burst_is_write      = st_q.wr;
	assign data_write_en       = st_q.wen;
	assign data_drive_en       = st_q.den;

	// checks
	property p_decode_act;
		@(posedge clk) disable iff (!rst_n)
		(run && !chip_select_n && !row_strobe_n && column_strobe_n && write_enable_n)
		|=> (cmd == sdcd_pkg::SDCD_CMD_ACTIVATE);
	endproperty
	a_decode_act: assert property (p_decode_act) else $error("activate not decoded"); // RQ2

	property p_desel;
		@(posedge clk) disable iff (!rst_n)
		(run && chip_select_n) |=> (cmd == sdcd_pkg::SDCD_CMD_DESELECT);
	endproperty
	a_desel: assert property (p_desel) else $error("deselect not decoded"); // RQ2

	property p_self;
		@(posedge clk) disable iff (!rst_n)
		(run && !bursting && !clock_enable && !chip_select_n && !row_strobe_n &&
		 !column_strobe_n && write_enable_n) |=> (pwr_state == sdcd_pkg::SDCD_PS_SELF);
	endproperty
	a_self: assert property (p_self) else $error("self refresh not entered"); // RQ3

	property p_no_pd_burst;
		@(posedge clk) disable iff (!rst_n)
		(run && bursting && !clock_enable) |=> (pwr_state == sdcd_pkg::SDCD_PS_SUSPEND);
	endproperty
	a_no_pd_burst: assert property (p_no_pd_burst) else $error("power-down in burst"); // RQ5

	property p_freeze;
		@(posedge clk) disable iff (!rst_n)
		(pwr_state == sdcd_pkg::SDCD_PS_SUSPEND && !clock_enable) |=> $stable(st_q.left);
	endproperty
	a_freeze: assert property (p_freeze) else $error("burst moved in suspend"); // RQ6

	property p_row;
		@(posedge clk) disable iff (!rst_n)
		(run && dec == sdcd_pkg::SDCD_CMD_ACTIVATE) |=> (row_addr == $past(addr));
	endproperty
	a_row: assert property (p_row) else $error("row not latched"); // RQ13

	property p_pre_all;
		@(posedge clk) disable iff (!rst_n)
		(run && dec == sdcd_pkg::SDCD_CMD_PRECHARGE && ap_in) |=> (bank_active == 4'h0);
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("precharge all failed"); // RQ15

	sequence s_ap_burst_end;
		(pwr_state == sdcd_pkg::SDCD_PS_RUN) && st_q.ap && (st_q.left == sdcd_pkg::SDCD_ONE);
	endsequence
	property p_ap;
		@(posedge clk) disable iff (!rst_n)
		s_ap_burst_end |=> !bank_active[$past(cmd_bank)];
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge missed"); // RQ14

	property p_exit;
		@(posedge clk) disable iff (!rst_n)
		(pwr_state == sdcd_pkg::SDCD_PS_PDOWN && clock_enable && chip_select_n)
		|=> (pwr_state == sdcd_pkg::SDCD_PS_RUN);
	endproperty
	a_exit: assert property (p_exit) else $error("power-down exit missed"); // RQ16

	property p_mask;
		@(posedge clk) disable iff (!rst_n)
		data_mask |=> (!data_write_en && !data_drive_en);
	endproperty
	a_mask: assert property (p_mask) else $error("data mask ignored"); // RQ17
endmodule

// *** tb/sdcd_ctrl_model.sv ***
`timescale 1ns/1ps
// controller side of the command pins, changed just after a rising edge
module sdcd_ctrl_model #(
	parameter int unsigned WAIT_CYC = 20000
) (
	input  wire logic   clk,
	output logic        chip_select_n,
	output logic        row_strobe_n,
	output logic        column_strobe_n,
	output logic        write_enable_n,
	output logic        clock_enable,
	output logic        data_mask,
	output logic        bank_select_lo,
	output logic        bank_select_hi,
	output logic [12:0] addr
);
	initial begin
		{chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h7;
		clock_enable = 1'b1;
		data_mask = 1'b1;
		{bank_select_hi, bank_select_lo} = 2'h0;
		addr = 13'h0000;
	end
	// one command cycle, then nop; stale address inverted so it is never reused
	task automatic send(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] a,
			input logic ck);
		@(posedge clk);
		{chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= code;
		{bank_select_hi, bank_select_lo} <= ba;
		addr <= a;
		clock_enable <= ck;
		@(posedge clk);
		{chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= 4'h7;
		addr <= ~a;
		#1;
	endtask
	// clock enable and mask alone
	task automatic pins(input logic ck, input logic m);
		@(posedge clk);
		clock_enable <= ck;
		data_mask <= m;
	endtask
	task automatic power_up(input logic [12:0] mode);
		repeat (WAIT_CYC) @(posedge clk);
		send(4'h2, 2'h0, 13'h0400, 1'b1);
		send(4'h0, 2'h0, mode, 1'b1);
		repeat (8) send(4'h1, 2'h0, 13'h0000, 1'b1);
		pins(1'b1, 1'b0);
	endtask
endmodule

// *** tb/sdram_command_decode_init_bench.sv ***
`timescale 1ns/1ps
`define chk(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: value mismatch", $time); end end
// decoder driven by the controller model, one command at a time
module sdram_command_decode_init_bench;
	logic                clk, rst_n, chip_select_n, row_strobe_n, column_strobe_n;
	logic                write_enable_n, clock_enable, data_mask, bank_select_lo, bank_select_hi;
	logic [12:0]         addr, row_addr, mode_word;
	sdcd_pkg::sdcd_cmd_t cmd;
	sdcd_pkg::sdcd_pwr_t pwr_state;
	logic [3:0]          bank_active;
	logic [9:0]          col_addr;
	logic [1:0]          cmd_bank;
	logic                auto_precharge_flag, burst_busy, burst_is_write;
	logic                data_write_en, data_drive_en;
	int                  mismatches = 0;
	int                  n_tests = 0;
	int                  cycles = 0;

	sdcd_decode DUT (.clk, .rst_n, .chip_select_n, .row_strobe_n, .column_strobe_n,
		.write_enable_n, .clock_enable, .data_mask, .bank_select_lo, .bank_select_hi, .addr,
		.cmd, .pwr_state, .bank_active, .row_addr, .col_addr, .cmd_bank, .auto_precharge_flag,
		.mode_word, .burst_busy, .burst_is_write, .data_write_en, .data_drive_en);
	// short pause keeps the run brief; the decoder has no count of its own
	sdcd_ctrl_model #(.WAIT_CYC(20)) ctrl (.clk, .chip_select_n, .row_strobe_n,
		.column_strobe_n, .write_enable_n, .clock_enable, .data_mask, .bank_select_lo,
		.bank_select_hi, .addr);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		$display("mismatches %0d, checks %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// hang guard, far above the hundred or so cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic step(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] a,
			input logic ck, input sdcd_pkg::sdcd_cmd_t exp);
		ctrl.send(code, ba, a, ck);
		`chk(cmd, exp)
	endtask
	initial begin
		rst_n = 1'b0;
		repeat (3) tick();
		`chk(cmd, sdcd_pkg::SDCD_CMD_NOP)
		`chk(pwr_state, sdcd_pkg::SDCD_PS_RUN)
		@(posedge clk) rst_n <= 1'b1;
		// burst length four, latency two
		ctrl.power_up(13'h0022);
		#1;
		`chk(mode_word, 13'h0022)
		`chk(bank_active, 4'h0)
		// open banks 1 and 2, close bank 2 only
		step(4'h3, 2'h1, 13'h1ABC, 1'b1, sdcd_pkg::SDCD_CMD_ACTIVATE);
		`chk(row_addr, 13'h1ABC)
		step(4'h3, 2'h2, 13'h0ABC, 1'b1, sdcd_pkg::SDCD_CMD_ACTIVATE);
		step(4'h2, 2'h2, 13'h1BFF, 1'b1, sdcd_pkg::SDCD_CMD_PRECHARGE);
		`chk(bank_active, 4'h2)
		// write with auto precharge, masked for one beat
		step(4'h4, 2'h1, 13'h0555, 1'b1, sdcd_pkg::SDCD_CMD_WRITE);
		`chk(col_addr, 10'h155)
		`chk({cmd_bank, auto_precharge_flag, burst_busy, burst_is_write}, 5'h0F)
		ctrl.pins(1'b1, 1'b1);
		ctrl.pins(1'b1, 1'b0);
		#1;
		`chk(data_write_en, 1'b0)
		tick();
		`chk(data_write_en, 1'b1)
		repeat (4) tick();
		`chk({burst_busy, bank_active}, 5'h00)
		// read without auto precharge, cut by burst stop
		step(4'h3, 2'h0, 13'h0010, 1'b1, sdcd_pkg::SDCD_CMD_ACTIVATE);
		step(4'h5, 2'h0, 13'h0003, 1'b1, sdcd_pkg::SDCD_CMD_READ);
		`chk({auto_precharge_flag, burst_is_write}, 2'h0)
		tick();
		`chk(data_drive_en, 1'b1)
		step(4'h6, 2'h0, 13'h0000, 1'b1, sdcd_pkg::SDCD_CMD_BURST_STOP);
		`chk({burst_busy, bank_active}, 5'h01)
		// clock enable low in a burst suspends it
		step(4'h5, 2'h0, 13'h0004, 1'b1, sdcd_pkg::SDCD_CMD_READ);
		ctrl.pins(1'b0, 1'b0);
		repeat (7) tick();
		`chk(pwr_state, sdcd_pkg::SDCD_PS_SUSPEND)
		`chk(burst_busy, 1'b1)
		ctrl.pins(1'b1, 1'b0);
		#1;
		tick();
		`chk({pwr_state, burst_busy}, {sdcd_pkg::SDCD_PS_RUN, 1'b1})
		repeat (6) tick();
		`chk(burst_busy, 1'b0)
		// power-down outside a burst ignores commands
		ctrl.pins(1'b0, 1'b0);
		step(4'h3, 2'h3, 13'h0001, 1'b0, sdcd_pkg::SDCD_CMD_NOP);
		`chk({pwr_state, bank_active}, {sdcd_pkg::SDCD_PS_PDOWN, 4'h1})
		step(4'h7, 2'h0, 13'h0000, 1'b1, sdcd_pkg::SDCD_CMD_NOP);
		tick();
		`chk(pwr_state, sdcd_pkg::SDCD_PS_RUN)
		// precharge all, then self refresh and exit on deselect
		step(4'h2, 2'h3, 13'h0400, 1'b1, sdcd_pkg::SDCD_CMD_PRECHARGE);
		`chk(bank_active, 4'h0)
		step(4'h1, 2'h0, 13'h0000, 1'b0, sdcd_pkg::SDCD_CMD_SELF_ENTRY);
		repeat (3) tick();
		`chk(pwr_state, sdcd_pkg::SDCD_PS_SELF)
		step(4'hF, 2'h0, 13'h0000, 1'b1, sdcd_pkg::SDCD_CMD_NOP);
		tick();
		`chk(pwr_state, sdcd_pkg::SDCD_PS_RUN)
		step(4'hF, 2'h0, 13'h0000, 1'b1, sdcd_pkg::SDCD_CMD_DESELECT);
		step(4'h7, 2'h0, 13'h0000, 1'b1, sdcd_pkg::SDCD_CMD_NOP);
		step(4'h1, 2'h0, 13'h0000, 1'b1, sdcd_pkg::SDCD_CMD_REFRESH);
		complete_run();
	end
endmodule
